/* verilog/dmv_pkg.sv */
package dmv_pkg;

    // Register byte addresses on the APB bus.
    localparam logic [7:0] DMV_CTRL_OFS = 8'h00;
    localparam logic [7:0] DMV_INSN_OFS = 8'h04;
    localparam logic [7:0] DMV_EXT_OFS = 8'h08;
    localparam logic [7:0] DMV_STAT_OFS = 8'h0C;
    localparam logic [7:0] DMV_FLAGS_OFS = 8'h10;
    localparam logic [7:0] DMV_GPR_OFS = 8'h20;

    // Field positions.
    localparam int DMV_CTRL_GO_BIT = 0;
    localparam int DMV_STAT_BUSY_BIT = 0;
    localparam int DMV_STAT_ERR_BIT = 1;
    localparam int DMV_STAT_LEN_POS = 8;
    localparam int DMV_STAT_ST_POS = 16;
    localparam int DMV_FLAG_I = 7;
    localparam int DMV_FLAG_H = 5;
    localparam int DMV_FLAG_N = 3;
    localparam int DMV_FLAG_Z = 2;
    localparam int DMV_FLAG_V = 1;
    localparam int DMV_FLAG_C = 0;

    // Values after reset.
    localparam logic [7:0] DMV_FLAGS_RST = 8'h80;
    localparam logic [31:0] DMV_GPR_RST = 32'h0000_0000;
    localparam logic [15:0] DMV_INSN_RST = 16'h0000;
    localparam logic [23:0] DMV_EXT_RST = 24'h00_0000;

    // Upper address bits of an 8-bit absolute address.
    localparam logic [15:0] DMV_ABS8_PAGE = 16'hFFFF;

    // Addressing forms of a move.
    typedef enum logic [3:0] {
        DMV_M_IMM = 4'h0,
        DMV_M_REG = 4'h1,
        DMV_M_IND = 4'h2,
        DMV_M_D16 = 4'h3,
        DMV_M_D24 = 4'h4,
        DMV_M_INC = 4'h5,
        DMV_M_DEC = 4'h6,
        DMV_M_A8 = 4'h7,
        DMV_M_A16 = 4'h8,
        DMV_M_A24 = 4'h9
    } dmv_mode_t;

    // Instruction descriptor written by software.
    typedef struct packed {
        logic [3:0] other_reg;
        logic [3:0] data_reg;
        logic [1:0] rsvd;
        logic word;
        logic store;
        dmv_mode_t mode;
    } dmv_insn_t;

    // Request toward memory and peripherals on the internal bus.
    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } dmv_mem_req_t;

    // Execution states.
    typedef enum logic [1:0] {
        DMV_S_IDLE = 2'b01,
        DMV_S_EXEC = 2'b10
    } dmv_state_t;

endpackage : dmv_pkg

/* verilog/dmv_core.sv */
`timescale 1ns/1ps

// Summary of operation
// RULE1: Sixteen word registers, R halves byte-addressable.
// RULE2: Moves set N, Z from value; clear V.
// RULE3: Moves keep I, H and C.
// RULE4: Byte post-increment load: read, then add one.
// RULE5: Word post-increment load: read, then add two.
// RULE6: Byte pre-decrement store: subtract one, then write.
// RULE7: Byte load displacement-24: eight bytes, ten states.
// RULE8: Byte store displacement-24: eight bytes, ten states.
// RULE9: Register and immediate moves: two or four states.
// RULE10: Absolute and indirect byte moves: listed lengths, states.
module dmv_core
    import dmv_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Internal bus master.
    output dmv_mem_req_t mem_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // Execution status.
    output logic busy_o
);

    dmv_state_t state_q;
    dmv_insn_t insn_q;
    logic [23:0] ext_q;
    logic [7:0] flags_q;
    logic [31:0] er_q [8];
    logic [3:0] len_q, states_q, cnt_q;
    dmv_mem_req_t mem_q;
    logic [15:0] val_q;
    logic [31:0] upd_q;
    logic [2:0] upd_idx_q;
    logic err_q, mem_pend_q, upd_en_q;

    // Bus access strobes.
    logic apb_acc, apb_wr, go, gpr_hit, mapped, finish;
    logic [2:0] gpr_idx;
    assign apb_acc = psel_i & penable_i;
    assign apb_wr = apb_acc & pwrite_i;
    assign gpr_hit = (paddr_i[7:5] == DMV_GPR_OFS[7:5]) &&
                     (paddr_i[1:0] == 2'h0);
    assign gpr_idx = paddr_i[4:2];
    assign mapped = gpr_hit || (paddr_i == DMV_CTRL_OFS) ||
                    (paddr_i == DMV_INSN_OFS) || (paddr_i == DMV_EXT_OFS) ||
                    (paddr_i == DMV_STAT_OFS) || (paddr_i == DMV_FLAGS_OFS);
    assign go = apb_wr && (paddr_i == DMV_CTRL_OFS) &&
                pwdata_i[DMV_CTRL_GO_BIT] && (state_q == DMV_S_IDLE);
    assign pready_o = 1'b1;
    assign pslverr_o = apb_acc & ~mapped;
    assign busy_o = (state_q == DMV_S_EXEC);
    assign mem_o = mem_q;
    // Byte operand: index 0..7 is the high half, 8..15 the low half.
    function automatic logic [7:0] rd8(input logic [31:0] r, input logic lo);
        rd8 = lo ? r[7:0] : r[15:8];
    endfunction : rd8
    // Word operand: index 0..7 is R, 8..15 is E.
    function automatic logic [15:0] rd16(input logic [31:0] r, input logic e);
        rd16 = e ? r[31:16] : r[15:0];
    endfunction : rd16
    // Decode of the pending descriptor at launch.
    logic [31:0] data_er, oth_er, base_er, new_base;
    logic [23:0] ea;
    logic [15:0] src_val;
    logic [3:0] len_d, states_d;
    logic base_upd, uses_mem, is_store, illegal;
    assign data_er = er_q[insn_q.data_reg[2:0]];
    assign oth_er = er_q[insn_q.other_reg[2:0]];
    assign base_er = oth_er;
    always_comb begin
        src_val = insn_q.word ? rd16(data_er, insn_q.data_reg[3])
                              : {8'h00, rd8(data_er, insn_q.data_reg[3])};
        ea = base_er[23:0];
        new_base = base_er;
        base_upd = 1'b0;
        uses_mem = 1'b1;
        is_store = insn_q.store;
        illegal = 1'b0;
        len_d = 4'h2;
        states_d = 4'h2;
        case (insn_q.mode)
            // RULE9: immediate move length.
            DMV_M_IMM: begin
                uses_mem = 1'b0;
                is_store = 1'b0;
                illegal = insn_q.store;
                len_d = insn_q.word ? 4'h4 : 4'h2;
                states_d = insn_q.word ? 4'h4 : 4'h2;
            end
            // RULE9: register to register.
            DMV_M_REG: begin
                uses_mem = 1'b0;
                is_store = 1'b0;
                illegal = insn_q.store;
            end
            // RULE10: register indirect timing.
            DMV_M_IND: begin
                states_d = 4'h4;
            end
            DMV_M_D16: begin
                ea = base_er[23:0] + {{8{ext_q[15]}}, ext_q[15:0]};
                len_d = 4'h4;
                states_d = 4'h6;
            end
            // RULE7: displacement-24 load timing.
            // RULE8: displacement-24 store timing.
            DMV_M_D24: begin
                ea = base_er[23:0] + ext_q;
                len_d = 4'h8;
                states_d = (insn_q.word && insn_q.store) ? 4'h8 : 4'hA;
            end
            // RULE4: byte increment by one.
            // RULE5: word increment by two.
            DMV_M_INC: begin
                is_store = 1'b0;
                illegal = insn_q.store;
                base_upd = 1'b1;
                new_base = base_er + (insn_q.word ? 32'h2 : 32'h1);
                states_d = 4'h6;
            end
            // RULE6: decrement before the write.
            DMV_M_DEC: begin
                is_store = 1'b1;
                illegal = ~insn_q.store;
                base_upd = 1'b1;
                new_base = base_er - (insn_q.word ? 32'h2 : 32'h1);
                ea = new_base[23:0];
                states_d = 4'h6;
            end
            // RULE10: absolute address forms.
            DMV_M_A8: begin
                ea = {DMV_ABS8_PAGE, ext_q[7:0]};
                illegal = insn_q.word;
                states_d = 4'h4;
            end
            DMV_M_A16: begin
                ea = {{8{ext_q[15]}}, ext_q[15:0]};
                len_d = 4'h4;
                states_d = 4'h6;
            end
            DMV_M_A24: begin
                ea = ext_q;
                len_d = 4'h6;
                states_d = 4'h8;
            end
            default: begin
                uses_mem = 1'b0;
                illegal = 1'b1;
            end
        endcase
        if (insn_q.mode == DMV_M_IMM) begin
            src_val = insn_q.word ? ext_q[15:0] : {8'h00, ext_q[7:0]};
        end else if (insn_q.mode == DMV_M_REG) begin
            src_val = insn_q.word ? rd16(oth_er, insn_q.other_reg[3])
                                  : {8'h00, rd8(oth_er, insn_q.other_reg[3])};
        end
    end
    // Sequencer: one state per clock, stretched while memory is pending.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= DMV_S_IDLE;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                DMV_S_IDLE: begin
                    if (go && !illegal) begin
                        state_q <= DMV_S_EXEC;
                        cnt_q <= states_d - 4'h1;
                    end
                end
                DMV_S_EXEC: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (!mem_pend_q) begin
                        state_q <= DMV_S_IDLE;
                    end
                end
                default: begin
                    state_q <= DMV_S_IDLE;
                end
            endcase
        end
    end
    // A move completes on this edge.
    assign finish = (state_q == DMV_S_EXEC) && (cnt_q == 4'h0) &&
                    !mem_pend_q;
    // Memory request: held until the bus acknowledges it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_q <= '0;
            mem_pend_q <= 1'b0;
        end else if (go && !illegal) begin
            mem_q.req <= uses_mem;
            mem_q.we <= is_store; // Also steers register write-back.
            mem_q.word <= insn_q.word;
            mem_q.addr <= ea;
            mem_q.wdata <= src_val;
            mem_pend_q <= uses_mem;
        end else if (mem_q.req && mem_ack_i) begin
            mem_q.req <= 1'b0;
            mem_pend_q <= 1'b0;
        end
    end
    // Transferred value, captured at launch or from read data.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            val_q <= 16'h0000;
        end else if (go && !illegal) begin
            val_q <= src_val;
        end else if (mem_q.req && mem_ack_i && !mem_q.we) begin
            val_q <= mem_q.word ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
        end
    end

    // Address register update, applied when the move completes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upd_q <= DMV_GPR_RST;
            upd_en_q <= 1'b0;
            upd_idx_q <= 3'h0;
        end else if (go && !illegal) begin
            upd_q <= new_base;
            upd_en_q <= base_upd;
            upd_idx_q <= insn_q.other_reg[2:0];
        end
    end

    // Descriptor, displacement and launch results.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            insn_q <= DMV_INSN_RST;
            ext_q <= DMV_EXT_RST;
            err_q <= 1'b0;
            len_q <= 4'h0;
            states_q <= 4'h0;
        end else begin
            if (apb_wr && paddr_i == DMV_INSN_OFS && !busy_o) begin
                insn_q <= pwdata_i[15:0];
            end
            if (apb_wr && paddr_i == DMV_EXT_OFS && !busy_o) begin
                ext_q <= pwdata_i[23:0];
            end
            if (go) begin
                err_q <= illegal;
                len_q <= illegal ? 4'h0 : len_d;
                states_q <= illegal ? 4'h0 : states_d;
            end
        end
    end

    // Flags: software write in any state except the completion cycle, where the move result wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= DMV_FLAGS_RST;
        end else if (finish) begin
            // RULE2: N and Z from value, V cleared.
            flags_q[DMV_FLAG_N] <= insn_q.word ? val_q[15] : val_q[7];
            flags_q[DMV_FLAG_Z] <= insn_q.word ? (val_q == 16'h0000)
                                              : (val_q[7:0] == 8'h00);
            flags_q[DMV_FLAG_V] <= 1'b0;
            // RULE3: I, H and C untouched.
            flags_q[DMV_FLAG_C] <= flags_q[DMV_FLAG_C];
        end else if (apb_wr && paddr_i == DMV_FLAGS_OFS) begin
            flags_q <= pwdata_i[7:0];
        end
    end

    // General registers, one writer per entry.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_er
            logic dst_hit, ld_wb;
            assign dst_hit = (insn_q.data_reg[2:0] == 3'(gi));
            assign ld_wb = finish && dst_hit && !mem_q.we;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    er_q[gi] <= DMV_GPR_RST;
                end else if (ld_wb || (finish && upd_en_q &&
                                       upd_idx_q == 3'(gi))) begin
                    // RULE4: post-increment applied after the read.
                    if (finish && upd_en_q && upd_idx_q == 3'(gi)) begin
                        er_q[gi] <= upd_q;
                    end
                    // RULE1: write a byte half or a word half.
                    if (ld_wb && insn_q.word && insn_q.data_reg[3]) begin
                        er_q[gi][31:16] <= val_q;
                    end else if (ld_wb && insn_q.word) begin
                        er_q[gi][15:0] <= val_q;
                    end else if (ld_wb && insn_q.data_reg[3]) begin
                        er_q[gi][7:0] <= val_q[7:0];
                    end else if (ld_wb) begin
                        er_q[gi][15:8] <= val_q[7:0];
                    end
                end else if (apb_wr && gpr_hit && gpr_idx == 3'(gi) &&
                             !busy_o) begin
                    er_q[gi] <= pwdata_i;
                end
            end
        end
    endgenerate

    // Read data, registered so it is valid in the access phase.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i) begin
            prdata_o <= 32'h0000_0000;
            if (gpr_hit) begin
                prdata_o <= er_q[gpr_idx];
            end else if (paddr_i == DMV_INSN_OFS) begin
                prdata_o <= {16'h0000, insn_q};
            end else if (paddr_i == DMV_EXT_OFS) begin
                prdata_o <= {8'h00, ext_q};
            end else if (paddr_i == DMV_FLAGS_OFS) begin
                prdata_o <= {24'h000000, flags_q};
            end else if (paddr_i == DMV_STAT_OFS) begin
                prdata_o[DMV_STAT_BUSY_BIT] <= busy_o;
                prdata_o[DMV_STAT_ERR_BIT] <= err_q;
                prdata_o[DMV_STAT_LEN_POS +: 4] <= len_q;
                prdata_o[DMV_STAT_ST_POS +: 4] <= states_q;
            end
        end
    end

endmodule : dmv_core

/* tb/dmv_core_props.sv */
`timescale 1ns/1ps
// Watches the core's bus and move timing at its ports.
module dmv_core_props
    import dmv_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave side.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Internal bus and status.
    input wire dmv_mem_req_t mem_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic go_w;
    // A start command completes on this access edge.
    assign go_w = psel_i && penable_i && pwrite_i
        && paddr_i == DMV_CTRL_OFS && pwdata_i[DMV_CTRL_GO_BIT];
    chk_go_launch: assert property ($rose(busy_o) |-> $past(go_w))
        else $error("busy rose without a start");
    chk_busy_min: assert property ($rose(busy_o) |-> busy_o[*2])
        else $error("move shorter than two states");
    chk_req_busy: assert property (mem_o.req |-> busy_o)
        else $error("bus request outside a move");
    chk_req_hold: assert property (mem_o.req && !mem_ack_i |=>
        mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
        else $error("request changed before answer");
    chk_ack_single: assert property (mem_ack_i |=> !mem_o.req)
        else $error("second access in one move");
    chk_ack_done: assert property (mem_ack_i |-> ##[0:10] !busy_o)
        else $error("move not finished after answer");
    chk_err_access: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("error outside access phase");
    chk_ctrl_zero: assert property (psel_i && penable_i && !pwrite_i
        && paddr_i == DMV_CTRL_OFS |-> prdata_o == 32'h0000_0000)
        else $error("control register read not zero");
    cover property ($rose(busy_o));
    cover property (mem_ack_i && mem_o.we);
    cover property (pslverr_o);
endmodule : dmv_core_props

bind dmv_core dmv_core_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
    .busy_o(busy_o));

/* tb/dmv_mem_model.sv */
`timescale 1ns/1ps
// Byte memory on the internal bus that answers after a set wait.
module dmv_mem_model
    import dmv_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Request and wait length.
    input wire dmv_mem_req_t mem_i,
    input wire logic [3:0] wait_i,
    // Answer.
    output logic [15:0] rdata_o,
    output logic ack_o
);
    logic [7:0] mem_q [256];
    logic [3:0] cnt_q;
    logic [7:0] a;
    // Waits, answers for one cycle; idle data toggles so it is never reused.
    always @(posedge clk_i) begin
        a = mem_i.addr[7:0];
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (rst_i || !mem_i.req || ack_o) begin
            cnt_q <= 4'h0;
            if (rst_i) rdata_o <= 16'hA5A5;
        end else if (cnt_q < wait_i) begin
            cnt_q <= cnt_q + 4'h1;
        end else begin
            ack_o <= 1'b1;
            rdata_o <= mem_i.word ? {mem_q[a], mem_q[a + 8'h01]}
                : {8'hEE, mem_q[a]};
            if (mem_i.we)
                mem_q[a] <= mem_i.word ? mem_i.wdata[15:8] : mem_i.wdata[7:0];
            if (mem_i.we && mem_i.word)
                mem_q[a + 8'h01] <= mem_i.wdata[7:0];
        end
    end
endmodule : dmv_mem_model

/* tb/test_dmv_core.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %0t: got %h exp %h", $time, g, e); end end
// Drives the core over APB and checks moves against a memory model.
module test_dmv_core;
    import dmv_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, pready_o, pslverr_o, mem_ack_i, busy_o, rd_err;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd_q;
    logic [15:0] mem_rdata_i;
    logic [3:0] mem_wait = 4'h0;
    dmv_mem_req_t mem_o;
    int errors = 0, check_count = 0, cycles = 0;
    dmv_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i), .busy_o(busy_o));
    dmv_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o),
        .wait_i(mem_wait), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
    // Clock of 4 ns period.
    always #2 clk_i = ~clk_i;
    // Cuts a hung run short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd_q = prdata_o;
        rd_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic gw(input logic [2:0] n, input logic [31:0] v);
        apb(1'b1, DMV_GPR_OFS + {3'h0, n, 2'b00}, v);
    endtask : gw
    task automatic gchk(input logic [2:0] n, input logic [31:0] e);
        apb(1'b0, DMV_GPR_OFS + {3'h0, n, 2'b00}, 32'h0000_0000);
        `CHK(rd_q, e)
    endtask : gchk
    task automatic fchk(input logic [7:0] e);
        apb(1'b0, DMV_FLAGS_OFS, 32'h0000_0000);
        `CHK(rd_q, {24'h00_0000, e})
    endtask : fchk
    // Starts a move, counts its busy states and checks the status fields.
    task automatic run_move(input dmv_insn_t ins, input logic [23:0] ext,
        input logic [3:0] st, input logic [3:0] len);
        int n;
        apb(1'b1, DMV_INSN_OFS, {16'h0000, ins});
        apb(1'b1, DMV_EXT_OFS, {8'h00, ext});
        apb(1'b1, DMV_CTRL_OFS, 32'h0000_0001);
        n = 0;
        @(negedge clk_i);
        while (busy_o === 1'b1) begin
            n++;
            @(negedge clk_i);
        end
        `CHK(4'(n), st)
        apb(1'b0, DMV_STAT_OFS, 32'h0000_0000);
        `CHK(rd_q, {12'h000, st, 4'h0, len, 8'h00})
    endtask : run_move
    task automatic t_reset();
        fchk(DMV_FLAGS_RST);
        gchk(3'h0, DMV_GPR_RST);
        apb(1'b0, DMV_CTRL_OFS, 32'h0000_0000);
        `CHK(rd_q, 32'h0000_0000)
        apb(1'b0, 8'hFC, 32'h0000_0000);
        `CHK({rd_err, rd_q}, 33'h0_0000_0000 | 33'h1_0000_0000)
    endtask : t_reset
    task automatic t_inc();
        u_mem.mem_q[8'h40] = 8'h85;
        u_mem.mem_q[8'h50] = 8'h00;
        u_mem.mem_q[8'h51] = 8'h00;
        gw(3'h1, 32'h0000_0040);
        gw(3'h2, 32'h0000_1234);
        apb(1'b1, DMV_FLAGS_OFS, 32'h0000_00A7);
        run_move('{4'h1, 4'hA, 2'h0, 1'b0, 1'b0, DMV_M_INC}, 24'h0, 4'h6,
            4'h2);
        gchk(3'h2, 32'h0000_1285);
        gchk(3'h1, 32'h0000_0041);
        fchk(8'hA9);
        gw(3'h4, 32'h0000_0050);
        gw(3'h3, 32'hBEEF_FFFF);
        mem_wait <= 4'h2;
        run_move('{4'h4, 4'h3, 2'h0, 1'b1, 1'b0, DMV_M_INC}, 24'h0, 4'h6,
            4'h2);
        gchk(3'h3, 32'hBEEF_0000);
        gchk(3'h4, 32'h0000_0052);
        fchk(8'hA5);
        mem_wait <= 4'h0;
    endtask : t_inc
    task automatic t_dec();
        u_mem.mem_q[8'h61] = 8'hCC;
        gw(3'h5, 32'h0000_0061);
        gw(3'h6, 32'h0000_7F00);
        apb(1'b1, DMV_FLAGS_OFS, 32'h0000_0002);
        run_move('{4'h5, 4'h6, 2'h0, 1'b0, 1'b1, DMV_M_DEC}, 24'h0, 4'h6,
            4'h2);
        `CHK({u_mem.mem_q[8'h60], u_mem.mem_q[8'h61]}, 16'h7FCC)
        gchk(3'h5, 32'h0000_0060);
        fchk(8'h00);
    endtask : t_dec
    task automatic t_disp();
        u_mem.mem_q[8'h30] = 8'h01;
        gw(3'h0, 32'h0000_0010);
        run_move('{4'h0, 4'h0, 2'h0, 1'b0, 1'b0, DMV_M_D24}, 24'h00_0020,
            4'hA, 4'h8);
        gchk(3'h0, 32'h0000_0110);
        gw(3'h7, 32'h0000_0070);
        run_move('{4'h7, 4'hF, 2'h0, 1'b0, 1'b1, DMV_M_D24}, 24'h00_0005,
            4'hA, 4'h8);
        `CHK(u_mem.mem_q[8'h75], 8'h70)
        run_move('{4'h7, 4'h7, 2'h0, 1'b1, 1'b1, DMV_M_D24}, 24'h00_0008,
            4'h8, 4'h8);
        `CHK({u_mem.mem_q[8'h78], u_mem.mem_q[8'h79]}, 16'h0070)
    endtask : t_disp
    task automatic t_timing();
        dmv_mode_t md [10] = '{DMV_M_IMM, DMV_M_IMM, DMV_M_REG, DMV_M_REG,
            DMV_M_IND, DMV_M_IND, DMV_M_D16, DMV_M_A8, DMV_M_A16, DMV_M_A24};
        logic wd [10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
            1'b0, 1'b0};
        logic [3:0] st [10] = '{4'h2, 4'h4, 4'h2, 4'h2, 4'h4, 4'h4, 4'h6,
            4'h4, 4'h6, 4'h8};
        logic [3:0] ln [10] = '{4'h2, 4'h4, 4'h2, 4'h2, 4'h2, 4'h2, 4'h4,
            4'h2, 4'h4, 4'h6};
        u_mem.mem_q[8'h10] = 8'h33;
        u_mem.mem_q[8'h11] = 8'h44;
        u_mem.mem_q[8'h20] = 8'h5A;
        for (int i = 0; i < 10; i++) begin
            run_move('{4'h0, 4'h1, 2'h0, wd[i], 1'b0, md[i]}, 24'h00_0020,
                st[i], ln[i]);
            if (i == 3) begin
                gchk(3'h1, 32'h0000_0110);
            end
        end
        gchk(3'h1, 32'h0000_5A44);
    endtask : t_timing
    task automatic t_illegal();
        apb(1'b1, DMV_INSN_OFS, {16'h0000, 4'h1, 4'h1, 8'h06});
        apb(1'b1, DMV_CTRL_OFS, 32'h0000_0001);
        @(negedge clk_i);
        `CHK(busy_o, 1'b0)
        apb(1'b0, DMV_STAT_OFS, 32'h0000_0000);
        `CHK(rd_q, 32'h0000_0002)
    endtask : t_illegal
    // Resets the core, then runs each scenario in turn.
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_inc();
        t_dec();
        t_disp();
        t_timing();
        t_illegal();
        finish_test();
    end
endmodule : test_dmv_core
